// file: common/smcg_pkg.sv
// Package with the sleep modes, states and timing constants of the clock gate.
package smcg_pkg;

    localparam int MODE_W = 3;

    typedef enum logic [2:0] {
        SMCG_IDLE     = 3'h0,
        SMCG_FROZEN   = 3'h1,
        SMCG_STANDBY  = 3'h2,
        SMCG_STOP     = 3'h3,
        SMCG_DEEP     = 3'h4,
        SMCG_STATIC   = 3'h5,
        SMCG_SHUTDOWN = 3'h6
    } smcg_mode_t;

    typedef enum logic [2:0] {
        SMCG_RUN      = 3'h0,
        SMCG_DRAIN    = 3'h1,
        SMCG_SLEEP    = 3'h2,
        SMCG_WALK     = 3'h3,
        SMCG_WAKE     = 3'h4
    } smcg_state_t;

    // Source restart time on wake before the CPU clock is released.
    localparam int SRC_START_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SRC_START_CYC =
        (SRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    localparam logic [2:0] MODE_MAX = 3'h6;
    localparam logic       FLAG_ON  = 1'h1;
    localparam logic       FLAG_OFF = 1'h0;

endpackage : smcg_pkg

// file: verilog/smcg_decode.sv
// Decoder from a sleep mode index to the set of domains that stay running.
`timescale 1ns/1ns
module smcg_decode
(
    input  wire logic [2:0] mode_in,
    output logic            cpu_run_out,
    output logic            hsb_run_out,
    output logic            pb_run_out,
    output logic            src_run_out,
    output logic            rc_run_out,
    output logic            bod_on_out,
    output logic            reg_normal_out,
    output logic            reg_on_out,
    output logic            sync_wake_out,
    output logic            async_wake_out
);

    always_comb
    begin
        cpu_run_out    = 1'h0;
        hsb_run_out    = mode_in < smcg_pkg::SMCG_FROZEN;
        pb_run_out     = mode_in < smcg_pkg::SMCG_STANDBY;
        src_run_out    = mode_in < smcg_pkg::SMCG_STOP;
        rc_run_out     = mode_in < smcg_pkg::SMCG_STATIC;
        bod_on_out     = mode_in < smcg_pkg::SMCG_DEEP;
        reg_normal_out = mode_in < smcg_pkg::SMCG_STOP;
        reg_on_out     = mode_in < smcg_pkg::SMCG_SHUTDOWN;
        sync_wake_out  = mode_in < smcg_pkg::SMCG_STANDBY;
        async_wake_out = mode_in < smcg_pkg::SMCG_SHUTDOWN;
    end

endmodule : smcg_decode

// file: verilog/smcg_sync.sv
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/1ns
module smcg_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } smcg_sync_t;

    smcg_sync_t st_q;
    smcg_sync_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.val[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.val;

endmodule : smcg_sync

// file: verilog/smcg_ctrl.sv
// Sleep mode controller that gates clocks, sources and supplies by mode.
//
// What this block does
// - Index 0 stops only the CPU clock.
// - Index 1 stops CPU and high-speed bus clocks.
// - Index 2 stops all synchronous clocks, sources keep running.
// - Index 3 also stops sources and count timer; regulator low power.
// - Index 4 also turns off the brownout detector.
// - Index 5 also stops the system RC oscillator.
// - Index 6 turns off the regulator; allowed only in 3.3V/1.8V setup.
// - Slow crystal keeps running only if enabled before sleep.
// - CPU passes mode index 0..6 with its sleep request.
// - Count timer clock stops with sources from index 3 upward.
// - Interrupts are synchronous wakes; timer, watchdog, pins are async.
// - Modes 0,1 accept both wake kinds; 2 to 5 async only.
// - In mode 1 synchronous wakes come only from peripheral bus.
// - In mode 5 watchdog wakes only when on pre-enabled slow crystal.
// - Mode 6 wakes only on reset pin, wake pin or async timer.
// - In modes 2 to 5 peripheral clock requests start their clock, source, generic clock and interrupt clock.
// - Async wake during partial wake keeps the requested clock running.
// - Each peripheral request is maskable; all enabled after reset.
// - Partial wake runs interrupt clock; pending interrupt wakes fully.
// - CPU held safe until its bus operations complete before sleep.
// - Peripheral read stalls CPU until earlier writes finish.
// - Wake restarts the CPU and all halted modules.
// - Sleep halts stopped domains regardless of clock mask bits.
`timescale 1ns/1ns
module smcg_ctrl
#(
    parameter int NREQ = 4
)
(
    input  wire logic            clk_in,
    input  wire logic            rstn_in,
    input  wire logic            sleep_req_in,
    input  wire logic [2:0]      sleep_mode_in,
    input  wire logic            cpu_bus_busy_in,
    input  wire logic            pb_read_in,
    input  wire logic            pb_write_pend_in,
    input  wire logic            supply_33_18_in,
    input  wire logic            slow_osc_en_in,
    input  wire logic            wdt_on_slow_osc_in,
    input  wire logic            irq_pending_in,
    input  wire logic            irq_from_pb_in,
    input  wire logic            async_timer_wake_in,
    input  wire logic            watchdog_wake_in,
    input  wire logic            ext_irq_wake_in,
    input  wire logic            ext_reset_wake_in,
    input  wire logic            wake_pin_in,
    input  wire logic            async_wake_enable_reg_wake_in,
    input  wire logic [NREQ-1:0] periph_req_in,
    input  wire logic [NREQ-1:0] periph_power_control_reg_mask_in,
    input  wire logic [NREQ-1:0] cpu_mask_in,
    input  wire logic [NREQ-1:0] hsb_mask_in,
    input  wire logic [NREQ-1:0] pb_mask_in,
    output logic                 cpu_stall_out,
    output logic                 sleeping_out,
    output logic                 partial_wake_out,
    output logic [NREQ-1:0]      cpu_clk_en_out,
    output logic [NREQ-1:0]      hsb_clk_en_out,
    output logic [NREQ-1:0]      pb_clk_en_out,
    output logic                 generic_clock_en_out,
    output logic                 clk_src_en_out,
    output logic                 cpu_count_timer_clock_en_out,
    output logic                 intc_clk_en_out,
    output logic                 slow_crystal_osc_en_out,
    output logic                 system_rc_osc_en_out,
    output logic                 brownout_detector_en_out,
    output logic                 reg_low_power_out,
    output logic                 reg_on_out,
    output logic                 mode_refused_out
);

    typedef struct packed {
        smcg_pkg::smcg_state_t              st;
        logic [2:0]                         mode;
        logic                               osc_pre;
        logic [NREQ-1:0]                    walk_req;
        logic [smcg_pkg::CNT_W-1:0]         cnt;
        logic                               refused;
        logic                               cpu;
        logic [NREQ-1:0]                    cpu_en;
        logic [NREQ-1:0]                    hsb_en;
        logic [NREQ-1:0]                    pb_en;
        logic                               generic_clock;
        logic                               src;
        logic                               rc;
        logic                               brownout_detector;
        logic                               lowp;
        logic                               regon;
        logic                               slow;
        logic                               intc;
    } smcg_state_s_t;

    smcg_state_s_t st_q;
    smcg_state_s_t st_d;

    logic cpu_run;
    logic hsb_run;
    logic pb_run;
    logic src_run;
    logic rc_run;
    logic bod_on;
    logic reg_norm;
    logic reg_on;
    logic sync_ok;
    logic async_ok;
    logic [5:0] pin_s;
    logic [NREQ-1:0] req_s;
    logic async_wake;
    logic sync_wake;
    logic [NREQ-1:0] req_ok;

    smcg_decode u_dec
    (
        .mode_in        (st_q.mode),
        .cpu_run_out    (cpu_run),
        .hsb_run_out    (hsb_run),
        .pb_run_out     (pb_run),
        .src_run_out    (src_run),
        .rc_run_out     (rc_run),
        .bod_on_out     (bod_on),
        .reg_normal_out (reg_norm),
        .reg_on_out     (reg_on),
        .sync_wake_out  (sync_ok),
        .async_wake_out (async_ok)
    );

    smcg_sync #(.WIDTH(6)) u_pin_sync
    (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in ({async_timer_wake_in, watchdog_wake_in, ext_irq_wake_in,
                    ext_reset_wake_in, wake_pin_in, async_wake_enable_reg_wake_in}),
        .sync_out (pin_s)
    );

    smcg_sync #(.WIDTH(NREQ)) u_req_sync
    (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (periph_req_in),
        .sync_out (req_s)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        if (st_q.mode == smcg_pkg::SMCG_SHUTDOWN)
        begin
            async_wake = pin_s[5] | pin_s[2] | pin_s[1];
        end
        else
        begin
            async_wake = async_ok & (pin_s[5] | pin_s[3] | pin_s[2]
                | pin_s[1] | pin_s[0]
                | (pin_s[4] & ((st_q.mode != smcg_pkg::SMCG_STATIC)
                   | (wdt_on_slow_osc_in & st_q.osc_pre))));
        end
        sync_wake = sync_ok & irq_pending_in
            & ((st_q.mode != smcg_pkg::SMCG_FROZEN) | irq_from_pb_in);
        req_ok = req_s & periph_power_control_reg_mask_in;
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_d = st_q;
        case (st_q.st)
            smcg_pkg::SMCG_RUN:
            begin
                st_d.cpu    = smcg_pkg::FLAG_ON;
                st_d.cpu_en = cpu_mask_in;
                st_d.hsb_en = hsb_mask_in;
                st_d.pb_en  = pb_mask_in;
                st_d.generic_clock   = smcg_pkg::FLAG_ON;
                st_d.src    = smcg_pkg::FLAG_ON;
                st_d.rc     = smcg_pkg::FLAG_ON;
                st_d.brownout_detector    = smcg_pkg::FLAG_ON;
                st_d.lowp   = smcg_pkg::FLAG_OFF;
                st_d.regon  = smcg_pkg::FLAG_ON;
                st_d.intc   = smcg_pkg::FLAG_ON;
                st_d.slow   = slow_osc_en_in;
                st_d.refused = smcg_pkg::FLAG_OFF;
                if (sleep_req_in)
                begin
                    if (sleep_mode_in > smcg_pkg::MODE_MAX
                        || (sleep_mode_in == smcg_pkg::SMCG_SHUTDOWN
                            && !supply_33_18_in))
                    begin
                        st_d.refused = smcg_pkg::FLAG_ON;
                    end
                    else
                    begin
                        st_d.mode    = sleep_mode_in;
                        st_d.osc_pre = slow_osc_en_in;
                        st_d.st      = smcg_pkg::SMCG_DRAIN;
                    end
                end
            end
            smcg_pkg::SMCG_DRAIN:
            begin
                if (!cpu_bus_busy_in && !pb_write_pend_in)
                begin
                    st_d.st = smcg_pkg::SMCG_SLEEP;
                end
            end
            smcg_pkg::SMCG_SLEEP, smcg_pkg::SMCG_WALK:
            begin
                st_d.cpu    = cpu_run;
                st_d.cpu_en = '0;
                st_d.hsb_en = hsb_run ? hsb_mask_in : '0;
                st_d.pb_en  = pb_run ? pb_mask_in : '0;
                st_d.generic_clock   = pb_run;
                st_d.src    = src_run;
                st_d.rc     = rc_run;
                st_d.brownout_detector    = bod_on;
                st_d.lowp   = !reg_norm;
                st_d.regon  = reg_on;
                st_d.slow   = st_q.osc_pre;
                st_d.intc   = pb_run;
                if (!pb_run && st_q.mode != smcg_pkg::SMCG_SHUTDOWN
                    && |req_ok)
                begin
                    st_d.st       = smcg_pkg::SMCG_WALK;
                    st_d.walk_req = req_ok;
                    st_d.pb_en    = req_ok & pb_mask_in;
                    st_d.generic_clock     = smcg_pkg::FLAG_ON;
                    st_d.src      = smcg_pkg::FLAG_ON;
                    st_d.intc     = smcg_pkg::FLAG_ON;
                end
                else if (st_q.st == smcg_pkg::SMCG_WALK)
                begin
                    st_d.st       = smcg_pkg::SMCG_SLEEP;
                    st_d.walk_req = '0;
                end
                if (async_wake || sync_wake
                    || (st_q.st == smcg_pkg::SMCG_WALK && irq_pending_in))
                begin
                    st_d.st  = smcg_pkg::SMCG_WAKE;
                    st_d.cnt = '0;
                end
            end
            smcg_pkg::SMCG_WAKE:
            begin
                st_d.hsb_en = hsb_mask_in;
                st_d.pb_en  = pb_mask_in;
                st_d.generic_clock   = smcg_pkg::FLAG_ON;
                st_d.src    = smcg_pkg::FLAG_ON;
                st_d.rc     = smcg_pkg::FLAG_ON;
                st_d.brownout_detector    = smcg_pkg::FLAG_ON;
                st_d.lowp   = smcg_pkg::FLAG_OFF;
                st_d.regon  = smcg_pkg::FLAG_ON;
                st_d.intc   = smcg_pkg::FLAG_ON;
                st_d.slow   = slow_osc_en_in;
                st_d.cnt    = st_q.cnt + 1'h1;
                if (st_q.cnt == smcg_pkg::CNT_W'(smcg_pkg::SRC_START_CYC))
                begin
                    st_d.st       = smcg_pkg::SMCG_RUN;
                    st_d.walk_req = '0;
                end
            end
            default:
            begin
                st_d.st = smcg_pkg::SMCG_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            st_q        <= '0;
            st_q.cpu    <= 1'h1;
            st_q.cpu_en <= '1;
            st_q.hsb_en <= '1;
            st_q.pb_en  <= '1;
            st_q.generic_clock   <= 1'h1;
            st_q.src    <= 1'h1;
            st_q.rc     <= 1'h1;
            st_q.brownout_detector    <= 1'h1;
            st_q.regon  <= 1'h1;
            st_q.intc   <= 1'h1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign cpu_stall_out = (pb_read_in & pb_write_pend_in)
        | (st_q.st != smcg_pkg::SMCG_RUN);
    assign sleeping_out  = st_q.st == smcg_pkg::SMCG_SLEEP
        || st_q.st == smcg_pkg::SMCG_WALK;
    assign partial_wake_out = st_q.st == smcg_pkg::SMCG_WALK;
    assign cpu_clk_en_out   = st_q.cpu ? st_q.cpu_en : '0;
    assign hsb_clk_en_out   = st_q.hsb_en;
    assign pb_clk_en_out    = st_q.pb_en;
    assign generic_clock_en_out = st_q.generic_clock;
    assign clk_src_en_out   = st_q.src;
    assign cpu_count_timer_clock_en_out = st_q.src;
    assign intc_clk_en_out  = st_q.intc;
    assign slow_crystal_osc_en_out  = st_q.slow;
    assign system_rc_osc_en_out     = st_q.rc;
    assign brownout_detector_en_out = st_q.brownout_detector;
    assign reg_low_power_out = st_q.lowp;
    assign reg_on_out       = st_q.regon;
    assign mode_refused_out = st_q.refused;

    ////////////////////////////////////////////////////////////////////////

    a_idle_hsb_runs: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (st_q.st == smcg_pkg::SMCG_SLEEP && st_q.mode == smcg_pkg::SMCG_IDLE)
        |-> ##1 (hsb_clk_en_out == hsb_mask_in))
        else $error("idle stopped the bus clock");
    a_frozen_hsb_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (sleeping_out && st_q.mode == smcg_pkg::SMCG_FROZEN
         && $past(sleeping_out))
        |-> hsb_clk_en_out == '0 && generic_clock_en_out)
        else $error("frozen mode gating wrong");
    a_stop_src_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (st_q.st == smcg_pkg::SMCG_SLEEP
         && $past(st_q.st) == smcg_pkg::SMCG_SLEEP
         && st_q.mode == smcg_pkg::SMCG_STOP)
        |-> !clk_src_en_out && reg_low_power_out
            && system_rc_osc_en_out)
        else $error("stop mode gating wrong");
    a_shutdown_guard: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (st_q.st == smcg_pkg::SMCG_RUN && sleep_req_in && !supply_33_18_in
         && sleep_mode_in == smcg_pkg::SMCG_SHUTDOWN)
        |=> mode_refused_out && st_q.st == smcg_pkg::SMCG_RUN)
        else $error("shutdown entered without supply config");
    a_drain_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (st_q.st == smcg_pkg::SMCG_DRAIN && cpu_bus_busy_in)
        |=> st_q.st == smcg_pkg::SMCG_DRAIN)
        else $error("sleep entered with bus busy");
    a_pb_stall: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (pb_read_in && pb_write_pend_in) |-> cpu_stall_out)
        else $error("read not stalled behind writes");
    a_cpu_last: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(st_q.st == smcg_pkg::SMCG_WAKE)
        |-> (!st_q.cpu)[*3] ##0 clk_src_en_out)
        else $error("cpu clock released too early");
    // slow crystal kept only if pre-enabled
    a_slow_osc_pre: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (sleeping_out && $past(sleeping_out))
        |-> slow_crystal_osc_en_out == st_q.osc_pre)
        else $error("slow crystal state wrong in sleep");

endmodule : smcg_ctrl

// file: tb/smcg_partner.sv
// Behavioural model of the CPU and peripheral bus side of the clock gate.
`timescale 1ns/1ns
module smcg_partner
#(
    parameter int BUSY_CYC = 4,
    parameter int WR_CYC   = 3
)
(
    input  wire logic clk_in,
    input  wire logic sleep_req_in,
    input  wire logic pb_write_in,
    output logic      cpu_bus_busy_out,
    output logic      pb_write_pend_out
);
    int busy_cnt = 0;
    int wr_cnt   = 0;
    ////////////////////////////////////////////////////////////////////////
    // outstanding bus operations
    // The CPU still has bus work in flight when it asks to sleep; the bus
    // masters are stopped, so the work runs out after a fixed time.
    always @(posedge clk_in)
    begin
        if (sleep_req_in)
            busy_cnt <= BUSY_CYC;
        else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
    end
    always @(posedge clk_in)
    begin
        if (pb_write_in)
            wr_cnt <= WR_CYC;
        else if (wr_cnt > 0)
            wr_cnt <= wr_cnt - 1;
    end
    assign cpu_bus_busy_out  = (busy_cnt != 0);
    assign pb_write_pend_out = (wr_cnt != 0);
endmodule : smcg_partner

// file: tb/tb.sv
// Self-checking testbench of the sleep mode clock gate.
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [23:0] exp;
        logic [23:0] care;
    } smcg_note_t;
    localparam logic [23:0] ALL = 24'hffffff;
    logic clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic sleep_req_in = 1'h0;
    logic [2:0] sleep_mode_in = 3'h0;
    logic pb_read_in = 1'h0;
    logic pb_write = 1'h0;
    logic supply_33_18_in = 1'h0;
    logic slow_osc_en_in = 1'h1;
    logic irq_pending_in = 1'h0;
    logic irq_from_pb_in = 1'h0;
    logic ext_irq_wake_in = 1'h0;
    logic ext_reset_wake_in = 1'h0;
    logic wake_pin_in = 1'h0;
    logic async_timer_wake_in = 1'h0;
    logic watchdog_wake_in = 1'h0;
    logic async_wake_enable_reg_wake_in = 1'h0;
    logic wdt_on_slow_osc_in = 1'h0;
    logic [3:0] periph_req_in = 4'h0;
    logic [3:0] periph_power_control_reg_mask_in = 4'hf;
    logic [3:0] cpu_mask_in = 4'hf;
    logic [3:0] hsb_mask_in = 4'hf;
    logic [3:0] pb_mask_in = 4'hf;
    logic cpu_bus_busy, pb_write_pend, cpu_stall_out, sleeping_out;
    logic partial_wake_out, generic_clock_en, intc_en, src_en, tmr_en, slow_en, rc_en;
    logic bod_en, reg_low_power_out, reg_on_out, mode_refused_out;
    logic [3:0] cpu_clk_en_out, hsb_clk_en_out, pb_clk_en_out;
    logic [23:0] obs;
    logic smp = 1'h0;
    smcg_note_t note_q[$];
    smcg_note_t cur_note;
    int bad_count = 0;
    int num_checks = 0;
    assign obs = {sleeping_out, cpu_stall_out, mode_refused_out,
        cpu_clk_en_out, hsb_clk_en_out, pb_clk_en_out, generic_clock_en, intc_en,
        src_en, tmr_en, slow_en, rc_en, bod_en, reg_low_power_out, reg_on_out};
    always #25 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    smcg_partner i_smcg_partner (.clk_in(clk_in), .sleep_req_in(sleep_req_in),
        .pb_write_in(pb_write), .cpu_bus_busy_out(cpu_bus_busy),
        .pb_write_pend_out(pb_write_pend));
    smcg_ctrl #(.NREQ(4)) i_smcg_ctrl (.clk_in(clk_in), .rstn_in(rstn_in),
        .sleep_req_in(sleep_req_in), .sleep_mode_in(sleep_mode_in),
        .cpu_bus_busy_in(cpu_bus_busy), .pb_read_in(pb_read_in),
        .pb_write_pend_in(pb_write_pend), .supply_33_18_in(supply_33_18_in),
        .slow_osc_en_in(slow_osc_en_in),
        .wdt_on_slow_osc_in(wdt_on_slow_osc_in),
        .irq_pending_in(irq_pending_in), .irq_from_pb_in(irq_from_pb_in),
        .async_timer_wake_in(async_timer_wake_in),
        .watchdog_wake_in(watchdog_wake_in),
        .ext_irq_wake_in(ext_irq_wake_in),
        .ext_reset_wake_in(ext_reset_wake_in), .wake_pin_in(wake_pin_in),
        .async_wake_enable_reg_wake_in(async_wake_enable_reg_wake_in), .periph_req_in(periph_req_in),
        .periph_power_control_reg_mask_in(periph_power_control_reg_mask_in), .cpu_mask_in(cpu_mask_in),
        .hsb_mask_in(hsb_mask_in), .pb_mask_in(pb_mask_in),
        .cpu_stall_out(cpu_stall_out), .sleeping_out(sleeping_out),
        .partial_wake_out(partial_wake_out), .cpu_clk_en_out(cpu_clk_en_out),
        .hsb_clk_en_out(hsb_clk_en_out), .pb_clk_en_out(pb_clk_en_out),
        .generic_clock_en_out(generic_clock_en), .clk_src_en_out(src_en),
        .cpu_count_timer_clock_en_out(tmr_en), .intc_clk_en_out(intc_en),
        .slow_crystal_osc_en_out(slow_en), .system_rc_osc_en_out(rc_en),
        .brownout_detector_en_out(bod_en),
        .reg_low_power_out(reg_low_power_out), .reg_on_out(reg_on_out),
        .mode_refused_out(mode_refused_out));
    ////////////////////////////////////////////////////////////////////////
    // The watcher compares every sampled output set with the oldest note.
    always @(posedge clk_in)
    begin
        if (smp === 1'h1)
        begin
            cur_note = note_q.pop_front();
            num_checks++;
            if (((obs ^ cur_note.exp) & cur_note.care) !== 24'h0)
            begin
                bad_count++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time,
                    obs, cur_note.exp);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] run_vec();
        return {3'h0, cpu_mask_in, hsb_mask_in, pb_mask_in, 4'hf,
            slow_osc_en_in, 4'hd};
    endfunction : run_vec
    function automatic logic [23:0] sleep_vec(input int m);
        return {3'h6, 4'h0, (m < 1) ? hsb_mask_in : 4'h0,
            (m < 2) ? pb_mask_in : 4'h0, m < 2, m < 2, m < 3, m < 3,
            slow_osc_en_in, m < 5, m < 4, m > 2, m < 6};
    endfunction : sleep_vec
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask : step
    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [23:0] exp, input logic [23:0] care);
        note_q.push_back('{exp, care});
        smp = 1'h1;
        step(1);
        smp = 1'h0;
    endtask : check
    task automatic wait_on(input int which, input logic lvl);
        int i;
        for (i = 0; i < 300; i++)
        begin
            if ((which == 0 ? sleeping_out : which == 1 ? cpu_stall_out
                : partial_wake_out) === lvl)
                return;
            step(1);
        end
        bad_count++;
        $display("CHECK FAILED at %0t: wait timed out", $time);
        complete_run();
    endtask : wait_on
    task automatic go_sleep(input int m);
        sleep_mode_in = 3'(m);
        sleep_req_in = 1'h1;
        step(1);
        sleep_req_in = 1'h0;
        wait_on(0, 1'h1);
        step(8);
    endtask : go_sleep
    task automatic wake_up(input int src);
        {async_wake_enable_reg_wake_in, watchdog_wake_in, async_timer_wake_in,
            ext_reset_wake_in, wake_pin_in, irq_pending_in} = 6'h1 << src;
        wait_on(1, 1'h0);
        {async_wake_enable_reg_wake_in, watchdog_wake_in, async_timer_wake_in,
            ext_reset_wake_in, wake_pin_in, irq_pending_in} = 6'h0;
        step(2);
    endtask : wake_up
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'heb8e));
        repeat (6) @(posedge clk_in);
        #5;
        rstn_in = 1'h1;
        step(5);
        pb_read_in = 1'h1;
        pb_write = 1'h1;
        step(1);
        pb_write = 1'h0;
        check(run_vec() | 24'h400000, ALL);
        step(4);
        check(run_vec(), ALL);
        pb_read_in = 1'h0;
        for (int m = 6; m < 8; m++)
        begin
            sleep_mode_in = 3'(m);
            sleep_req_in = 1'h1;
            step(1);
            sleep_req_in = 1'h0;
            check(run_vec() | 24'h200000, ALL);
            check(run_vec(), ALL);
        end
        for (int m = 0; m < 6; m++)
        begin
            {cpu_mask_in, hsb_mask_in, pb_mask_in} = 12'($urandom);
            slow_osc_en_in = 1'($urandom) | (m == 5);
            go_sleep(m);
            check(sleep_vec(m), ALL);
            if (m > 0)
            begin
                irq_pending_in = 1'h1;
                watchdog_wake_in = (m == 5);
                step(20);
                watchdog_wake_in = 1'h0;
                check(sleep_vec(m), ALL);
                wdt_on_slow_osc_in = (m == 5);
            end
            irq_from_pb_in = 1'h1;
            wake_up((m < 2) ? 0 : m - 1);
            irq_from_pb_in = 1'h0;
            check(run_vec(), ALL);
        end
        supply_33_18_in = 1'h1;
        go_sleep(6);
        ext_irq_wake_in = 1'h1;
        step(20);
        ext_irq_wake_in = 1'h0;
        check(sleep_vec(6), ALL);
        wake_up(3);
        check(run_vec(), ALL);
        go_sleep(3);
        periph_power_control_reg_mask_in = 4'he;
        periph_req_in = 4'h1;
        step(20);
        check(sleep_vec(3), ALL);
        periph_power_control_reg_mask_in = 4'hf;
        wait_on(2, 1'h1);
        step(2);
        check({3'h6, 8'h0, 4'h1 & pb_mask_in, 4'hf, slow_osc_en_in, 4'hf},
            ALL);
        wake_up(5);
        check(run_vec(), ALL);
        periph_req_in = 4'h0;
        step(2);
        complete_run();
    end
endmodule : tb
